// ===== acc_host.sv
// host controller driving the sampling converter's pins
`timescale 1ns/1ps
module acc_host
   import acc_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // user side
   input  wire logic        req,
   input  wire logic [2:0]  next_channel,
   input  wire logic        auto_pd,
   input  wire logic        int_ref,
   output logic             busy,
   output logic             timeout_err,
   // result stream: {channel, data}
   output logic             res_valid,
   input  wire logic        res_ready,
   output logic [10:0]      res_data,
   // converter pins
   output logic             conv_start_n,
   output logic             cs_n,
   output logic             rd_n,
   output logic             channel_addr_bit2,
   output logic             channel_addr_bit1,
   output logic             channel_addr_bit0,
   input  wire logic        eoc_n,
   input  wire logic [7:0]  db_in
);
   //-------------------------------------------------------------------
   // pin synchronisers
   //-------------------------------------------------------------------
   logic [2:0] eoc_sync_reg;
   logic [7:0] db_s1_reg, db_s2_reg, db_s3_reg;
   logic       eoc_rise;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eoc_sync_reg <= 3'h7;
         db_s1_reg    <= 8'h00;
         db_s2_reg    <= 8'h00;
         db_s3_reg    <= 8'h00;
      end else begin
         eoc_sync_reg <= {eoc_sync_reg[1:0], eoc_n};
         db_s1_reg    <= db_in;
         db_s2_reg    <= db_s1_reg;
         db_s3_reg    <= db_s2_reg;
      end
   end
   // a rise counts once stages two and three are both high
   assign eoc_rise = eoc_sync_reg[1] && eoc_sync_reg[2];

   //-------------------------------------------------------------------
   // control state machine
   //-------------------------------------------------------------------
   acc_state_t       st_reg, st_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic             powered_reg, powered_next;
   logic             cs_reg, cs_next, rd_reg, rd_next, cv_reg, cv_next;
   logic [2:0]       ch_reg, ch_next, cur_reg, cur_next, used_reg, used_next;
   logic [7:0]       data_reg, data_next;
   logic             seen_low_reg, seen_low_next;
   logic             err_reg, err_next;
   logic             fifo_in_ready;

   always_comb begin
      st_next       = st_reg;
      cnt_next      = cnt_reg;
      powered_next  = powered_reg;
      cs_next       = cs_reg;
      rd_next       = rd_reg;
      cv_next       = cv_reg;
      ch_next       = ch_reg;
      cur_next      = cur_reg;
      used_next     = used_reg;
      data_next     = data_reg;
      seen_low_next = seen_low_reg;
      err_next      = 1'b0;
      case (st_reg)
         ST_IDLE: begin
            if (req) begin
               if (powered_reg) begin
                  cv_next       = 1'b0;
                  seen_low_next = 1'b0;
                  cnt_next      = '0;
                  st_next       = ST_CONV;
               end else begin
                  cv_next  = 1'b1;
                  cnt_next = int_ref ? CNT_W'(PWRUP_INT_CYC) : CNT_W'(PWRUP_EXT_CYC);
                  st_next  = ST_PWRUP;
               end
            end
         end
         ST_PWRUP: begin
            // wait full power-up for either reference
            if (cnt_reg <= CNT_W'(1)) begin
               powered_next  = 1'b1;
               cv_next       = 1'b0;
               seen_low_next = 1'b0;
               cnt_next      = '0;
               st_next       = ST_CONV;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ST_CONV: begin
            cnt_next = cnt_reg + 1'b1;
            // high-speed: release start before conversion ends
            if (!auto_pd) begin
               cv_next = 1'b1;
            end
            if (!eoc_sync_reg[2]) begin
               seen_low_next = 1'b1;
            end
            // capture once the end pulse has risen again, then read
            if (seen_low_reg && eoc_rise) begin
               // mode chosen by start level at eoc rise
               powered_next = !auto_pd;
               cv_next      = 1'b1;
               cs_next      = 1'b0;
               rd_next      = 1'b0;
               cnt_next     = '0;
               st_next      = ST_READ;
            end else if (cnt_reg == CNT_W'(EOC_WAIT_CYC)) begin
               // end pulse missed: read anyway, result is still pushed
               err_next     = 1'b1;
               powered_next = !auto_pd;
               cv_next      = 1'b1;
               cs_next      = 1'b0;
               rd_next      = 1'b0;
               cnt_next     = '0;
               st_next      = ST_READ;
            end
         end
         ST_READ: begin
            // read works in either power state
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == CNT_W'(RD_LOW_CYC + 2)) begin
               data_next = db_s3_reg;
               rd_next   = 1'b1;
               cs_next   = 1'b1;
               // data came from the channel latched one read earlier
               cur_next  = used_reg;
               used_next = ch_reg;
               cnt_next  = '0;
               st_next   = ST_PUSH;
            end
         end
         ST_PUSH: begin
            if (fifo_in_ready) begin
               ch_next  = next_channel;
               cnt_next = '0;
               st_next  = ST_ACQ;
            end
         end
         ST_ACQ: begin
            // acquisition gap after read ends
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg >= CNT_W'(ACQ_CYC)) begin
               st_next = ST_IDLE;
            end
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg       <= ST_IDLE;
         cnt_reg      <= '0;
         powered_reg  <= 1'b0;
         cs_reg       <= 1'b1;
         rd_reg       <= 1'b1;
         cv_reg       <= 1'b0;
         ch_reg       <= CH_RESET;
         cur_reg      <= CH_RESET;
         used_reg     <= CH_RESET;
         data_reg     <= 8'h00;
         seen_low_reg <= 1'b0;
         err_reg      <= 1'b0;
      end else begin
         st_reg       <= st_next;
         cnt_reg      <= cnt_next;
         powered_reg  <= powered_next;
         cs_reg       <= cs_next;
         rd_reg       <= rd_next;
         cv_reg       <= cv_next;
         ch_reg       <= ch_next;
         cur_reg      <= cur_next;
         used_reg     <= used_next;
         data_reg     <= data_next;
         seen_low_reg <= seen_low_next;
         err_reg      <= err_next;
      end
   end

   //-------------------------------------------------------------------
   // result fifo and outputs
   //-------------------------------------------------------------------
   logic        fv;
   logic [10:0] fd;
   logic        busy_reg;
   acc_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (st_reg == ST_PUSH),
      .in_ready  (fifo_in_ready),
      .in_data   ({cur_reg, data_reg}),
      .out_valid (fv),
      .out_ready (res_ready),
      .out_data  (fd)
   );
   assign res_valid = fv;
   assign res_data  = fd;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= (st_next != ST_IDLE);
      end
   end
   assign busy              = busy_reg;
   assign timeout_err       = err_reg;
   assign conv_start_n      = cv_reg;
   assign cs_n              = cs_reg;
   assign rd_n              = rd_reg;
   assign channel_addr_bit2 = ch_reg[2];
   assign channel_addr_bit1 = ch_reg[1];
   assign channel_addr_bit0 = ch_reg[0];

   //-------------------------------------------------------------------
   // assertions
   //-------------------------------------------------------------------
   a_start_rise_pwr: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_IDLE && req && !powered_reg) |=> conv_start_n ##1 conv_start_n)
      else $error("power-up edge missing");
   a_pwrup_len: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(st_reg == ST_PWRUP) && !int_ref |-> conv_start_n [*8])
      else $error("power-up too short");
   a_conv_low: assert property (@(posedge clk) disable iff (!rst_n)
      (st_next == ST_CONV && st_reg != ST_CONV) |=> !conv_start_n)
      else $error("conversion not started");
   a_read_strobe: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(rd_n) |-> !cs_n ##1 !rd_n)
      else $error("read without select");
   a_read_end: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(rd_n) |-> ##[3:6] rd_n)
      else $error("read not ended");
   a_conv_bound: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(st_reg == ST_CONV) |-> ##[1:20] st_reg != ST_CONV)
      else $error("conversion wait unbounded");
   a_pd_hold_low: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_CONV && auto_pd && !cv_reg) |=> !conv_start_n || $fell(rd_n))
      else $error("start released early");
   a_chan_stable: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_READ) |=> $stable(ch_reg))
      else $error("channel moved in read");
   a_acq_gap: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rd_n) |-> conv_start_n [*2])
      else $error("acquisition gap short");
   c_conv_done: cover property (@(posedge clk) disable iff (!rst_n) $rose(st_reg == ST_PUSH));
   c_powerup:   cover property (@(posedge clk) disable iff (!rst_n) $rose(st_reg == ST_PWRUP));
   c_timeout:   cover property (@(posedge clk) disable iff (!rst_n) timeout_err);
   c_backpress: cover property (@(posedge clk) disable iff (!rst_n)
      st_reg == ST_PUSH && !fifo_in_ready);
endmodule

// ===== acc_pkg.sv
// constants and types for the converter host controller
//----------------------------------------------------------------------
// Function
// - host holds start line defined from reset
// - internal ref: no falling edge before 25 us
// - high-speed: wait 30 ns after read before start
// - power-down: hold start low past end pulse
// - chip select may be tied low permanently
// - end pulse may drive select and read directly
//----------------------------------------------------------------------
package acc_pkg;
   localparam int CLK_PERIOD_NS   = 40;
   localparam int PWRUP_EXT_US    = 1;
   localparam int PWRUP_INT_US    = 25;
   localparam int PWRUP_EXT_CYC   = (PWRUP_EXT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PWRUP_INT_CYC   = (PWRUP_INT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_MAX_NS     = 420;
   localparam int EOC_MAX_NS      = 110;
   localparam int MODE_SAMPLE_NS  = 530;
   localparam int ACQ_MIN_NS      = 30;
   localparam int ACQ_CYC         = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // wait for end pulse: conversion plus pulse, plus sync slack
   localparam int EOC_WAIT_CYC    = (CONV_MAX_NS + EOC_MAX_NS) / CLK_PERIOD_NS + 4;
   localparam int RD_LOW_CYC      = 2;
   localparam int CNT_W           = 10;
   localparam logic [2:0] CH_RESET = 3'h0;

   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_PWRUP = 7'h02,
      ST_CONV  = 7'h04,
      ST_READ  = 7'h08,
      ST_HOLD  = 7'h10,
      ST_ACQ   = 7'h20,
      ST_PUSH  = 7'h40
   } acc_state_t;
endpackage

// ===== acc_fifo.sv
// result fifo, parameterised width and depth
`timescale 1ns/1ps
module acc_fifo
   import acc_pkg::*;
#(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // write side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // read side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0]      cnt_reg, cnt_next;
   logic             ov_reg, ov_next;
   logic [WIDTH-1:0] od_reg, od_next;
   logic             wr, rd;

   always_comb begin
      wr       = in_valid && (cnt_reg != (AW+1)'(DEPTH));
      rd       = out_ready && (cnt_reg != '0);
      wp_next  = wr ? ((wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1) : wp_reg;
      rp_next  = rd ? ((rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1) : rp_reg;
      cnt_next = cnt_reg + (AW+1)'(wr) - (AW+1)'(rd);
      // head kept in flops; a write into an emptying queue bypasses memory
      ov_next  = (cnt_next != '0);
      od_next  = (wr && (wp_reg == rp_next)) ? in_data : mem_reg[rp_next];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
         ov_reg  <= 1'b0;
         od_reg  <= '0;
      end else begin
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
         ov_reg  <= ov_next;
         od_reg  <= od_next;
      end
   end

   always_ff @(posedge clk) begin
      if (wr) begin
         mem_reg[wp_reg] <= in_data;
      end
   end

   assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = ov_reg;
   assign out_data  = od_reg;
endmodule

// ===== acc_dev_model.sv
// behavioural model of the sampling converter at its pins
`timescale 1ns/1ps
module acc_dev_model #(
   parameter int CONV_NS = 300,
   parameter int EOC_NS  = 80
) (
   // host pins
   input  wire logic       conv_start_n,
   input  wire logic       cs_n,
   input  wire logic       rd_n,
   input  wire logic [2:0] addr,
   output logic            eoc_n,
   output logic [7:0]      db,
   // test controls and observation
   input  wire logic       int_ref,
   input  wire logic       mute,
   output logic            powered,
   output int              viol
);
   // ------------------------------
   // state
   // ------------------------------
   logic [2:0] ch      = 3'h0;
   logic [7:0] result  = 8'h00;
   logic       pending = 1'b0;
   logic       eoc_int = 1'b1;
   realtime    t_rd    = 0.0;
   realtime    t_up    = 0.0;

   initial begin
      powered = 1'b0;
      viol    = 0;
   end
   assign eoc_n = eoc_int;
   // ------------------------------
   // power and conversion
   // ------------------------------
   task automatic convert();
      #(CONV_NS);
      result  = {~ch, 2'b10, ch};
      eoc_int = mute;
      // pulse cut short by a read strobe rise
      for (int i = 0; i < EOC_NS && (mute || !eoc_int); i++) #1;
      eoc_int = 1'b1;
      powered = conv_start_n;
   endtask

   always @(posedge conv_start_n) begin
      if (!powered) begin
         t_up = $realtime;
         #(int_ref ? 25000 : 1000);
         powered = 1'b1;
         if (pending) begin
            pending = 1'b0;
            convert();
         end
      end
   end

   always @(negedge conv_start_n) begin
      if ($realtime > 0.0) begin
         if ($realtime - t_rd < 30.0) viol++;
         if (powered) convert();
         else if (int_ref && $realtime - t_up < 24999.0) viol++;
         else pending = 1'b1;
      end
   end
   // ------------------------------
   // read port
   // ------------------------------
   // released bus shows the inverted result
   assign db = (!cs_n && !rd_n) ? result : ~result;

   always @(negedge rd_n) begin
      if (!cs_n) ch = addr;
   end

   always @(posedge rd_n) begin
      t_rd = $realtime;
      if (!eoc_int) eoc_int = 1'b1;
   end
endmodule

// ===== acc_host_tb.sv
// self-checking bench for the converter host controller
`timescale 1ns/1ps
module acc_host_tb;
   import acc_pkg::*;
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
   $display("unexpected at %0t got %h expected %h", $time, (got), (exp)); end end
   // ------------------------------
   // signals
   // ------------------------------
   typedef struct packed {
      logic       ap;
      logic       ir;
      logic [2:0] nc;
      logic [2:0] ch;
   } acc_row_t;
   acc_row_t    rows [7] = '{8'h58, 8'ha8, 8'h3b, 8'h0d, 8'h97, 8'he1, 8'h72};
   logic        clk, rst_n, req, auto_pd, int_ref, res_ready, mute;
   logic [2:0]  next_channel;
   logic        busy, timeout_err, res_valid, conv_start_n, cs_n, rd_n, eoc_n, powered;
   logic        channel_addr_bit2, channel_addr_bit1, channel_addr_bit0;
   logic [10:0] res_data;
   logic [7:0]  db_in;
   int          viol;
   int          to_cnt   = 0;
   int          failures = 0;
   int          compares = 0;

   acc_host #(.FIFO_DEPTH(8)) dut (
      .clk(clk), .rst_n(rst_n), .req(req), .next_channel(next_channel),
      .auto_pd(auto_pd), .int_ref(int_ref), .busy(busy), .timeout_err(timeout_err),
      .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
      .conv_start_n(conv_start_n), .cs_n(cs_n), .rd_n(rd_n),
      .channel_addr_bit2(channel_addr_bit2), .channel_addr_bit1(channel_addr_bit1),
      .channel_addr_bit0(channel_addr_bit0), .eoc_n(eoc_n), .db_in(db_in));

   acc_dev_model dev (
      .conv_start_n(conv_start_n), .cs_n(cs_n), .rd_n(rd_n),
      .addr({channel_addr_bit2, channel_addr_bit1, channel_addr_bit0}),
      .eoc_n(eoc_n), .db(db_in), .int_ref(int_ref), .mute(mute),
      .powered(powered), .viol(viol));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      if (timeout_err === 1'b1) to_cnt++;
   end
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic final_report();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic start_conv(input logic ap, input logic ir, input logic [2:0] nc);
      int n = 0;
      @(negedge clk);
      auto_pd      = ap;
      int_ref      = ir;
      next_channel = nc;
      req          = 1'b1;
      while (busy !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      req = 1'b0;
   endtask

   task automatic wait_idle();
      int n = 0;
      while (busy !== 1'b0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic pop(input logic [2:0] ch);
      int n = 0;
      @(negedge clk);
      while (res_valid !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      `CHECK(res_data, {ch, ~ch, 2'b10, ch})
      res_ready = 1'b1;
      @(negedge clk);
      res_ready = 1'b0;
   endtask
   // ------------------------------
   // sequence
   // ------------------------------
   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      final_report();
   end

   initial begin
      rst_n        = 1'b0;
      req          = 1'b0;
      next_channel = 3'h0;
      auto_pd      = 1'b0;
      int_ref      = 1'b0;
      res_ready    = 1'b0;
      mute         = 1'b0;
      repeat (8) @(negedge clk);
      `CHECK({conv_start_n, cs_n, rd_n, busy, res_valid}, 5'b01100)
      `CHECK({channel_addr_bit2, channel_addr_bit1, channel_addr_bit0, powered}, 4'h0)
      rst_n = 1'b1;
      foreach (rows[i]) begin
         start_conv(rows[i].ap, rows[i].ir, rows[i].nc);
         wait_idle();
         pop(rows[i].ch);
         `CHECK(powered, ~rows[i].ap)
      end
      // fill the result buffer with the reader stalled
      for (int k = 0; k < 9; k++) begin
         start_conv(1'b0, 1'b0, 3'(k + 2));
         if (k < 8) wait_idle();
      end
      repeat (40) @(negedge clk);
      `CHECK({busy, cs_n, rd_n, res_valid}, 4'hf)
      // leave the device on channel zero before the mid-run reset
      next_channel = 3'h0;
      for (int k = 0; k < 9; k++) begin
         pop(k < 2 ? (k == 0 ? 3'h4 : 3'h6) : 3'(k));
      end
      wait_idle();
      // end pulse withheld by the device
      mute = 1'b1;
      start_conv(1'b0, 1'b0, 3'h0);
      wait_idle();
      mute = 1'b0;
      pop(3'h1);
      `CHECK(to_cnt, 1)
      // reset in mid-run with the device powered
      rst_n = 1'b0;
      repeat (20) @(negedge clk);
      `CHECK({conv_start_n, cs_n, rd_n, busy, res_valid}, 5'b01100)
      `CHECK(powered, 1'b0)
      rst_n = 1'b1;
      start_conv(1'b1, 1'b0, 3'h5);
      wait_idle();
      pop(3'h0);
      `CHECK(viol, 0)
      final_report();
   end
endmodule
